// file: rtl/fept_map.vh
/*
 * register indexes, field positions and reset values of the fiber
 * event and pattern test block.
 * assumes a 32-bit classic wishbone slave: byte address = 4 * index.
 */
// Overview of operation
// - speed change latches event bit 14 until the event register is read
// - duplex change latches event bit 13 until read
// - received base or next page latches event bit 12 until read
// - negotiation complete latches event bit 11 until read
// - link up/down change latches event bit 10 until read
// - symbol error latches bit 9, false carrier bit 8, until read
// - elastic fifo over/underflow latches event bit 7 until read
// - energy-detect toggle either way latches event bit 4 until read
// - receive error tally is 16 bits and sticks at 0xFFFF
// - both false carrier and symbol error bump the receive tally
// - with lock-wait set, checker tally waits for pattern lock, again after a pattern change
// - writing 1 to clear bit 4 zeroes the high half and restarts the count from that cycle's error; bit self-clears
// - selector 11 makes the generator emit alternating one-zero
// - reading the low half freezes the high half for a coherent pair
// - high half refreshes only by a prior low read or the clear bit; read low first
`ifndef FEPT_MAP_VH
`define FEPT_MAP_VH

// ***************************************************************
// register indexes
// ***************************************************************
`define FEPT_IDX_SOFT_RESET 6'h00
`define FEPT_IDX_EVENT 6'h13
`define FEPT_IDX_RX_TALLY 6'h15
`define FEPT_IDX_PAT_CTRL 6'h17
`define FEPT_IDX_PAT_LOW 6'h18
`define FEPT_IDX_PAT_HIGH 6'h19

// ***************************************************************
// fields
// ***************************************************************
`define FEPT_EV_SPEED 14
`define FEPT_EV_DUPLEX 13
`define FEPT_EV_PAGE 12
`define FEPT_EV_ANEG 11
`define FEPT_EV_LINK 10
`define FEPT_EV_SYMBOL 9
`define FEPT_EV_FALSE_CAR 8
`define FEPT_EV_FIFO 7
`define FEPT_EV_ENERGY 4
`define FEPT_CT_GEN_EN 0
`define FEPT_CT_CHK_EN 1
`define FEPT_CT_SEL_LO 2
`define FEPT_CT_CLEAR 4
`define FEPT_CT_LOCK_WAIT 5
`define FEPT_CT_INV_GEN 6
`define FEPT_CT_INV_CHK 7
`define FEPT_SOFT_RESET_BIT 15

// ***************************************************************
// encodings and reset values
// ***************************************************************
`define FEPT_SEL_PRBS7 2'h0
`define FEPT_SEL_PRBS23 2'h1
`define FEPT_SEL_PRBS31 2'h2
`define FEPT_SEL_ALT 2'h3
`define FEPT_CTRL_RST 16'h0000
`define FEPT_ENERGY_RST 1'h1
`define FEPT_TALLY_MAX 16'hFFFF
`define FEPT_LFSR_SEED 31'h7FFFFFFF
`define FEPT_LOCK_RUN 6'h20

`endif

// file: rtl/fept_top.v
/*
 * fiber event latches, receive error tally and pattern generator /
 * checker with a classic wishbone register port.
 * assumes status inputs and the serial pattern bits are produced by
 * logic on I_SYS_CLK, one pattern bit per clock.
 */
`timescale 1ns/10ps
`include "fept_map.vh"

module fept_top #(
  parameter LOCK_RUN = `FEPT_LOCK_RUN
) (
  input wire I_SYS_CLK,
  input wire I_RST_B,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  input wire [1:0] I_SPEED,
  input wire I_DUPLEX,
  input wire I_PAGE_RX,
  input wire I_ANEG_DONE,
  input wire I_LINK_UP,
  input wire I_SYMBOL_ERR,
  input wire I_FALSE_CARRIER,
  input wire I_FIFO_ERR,
  input wire I_NO_ENERGY,
  input wire I_PAT_RX,
  output reg O_PAT_TX,
  output reg O_PAT_LOCK
);

  // ***************************************************************
  // functions
  // ***************************************************************
  // next feedback bit of the selected sequence, shifting toward msb
  function fb_bit;
    input [30:0] s;
    input [1:0] sel;
    begin
      case (sel)
        `FEPT_SEL_PRBS7: fb_bit = s[6] ^ s[5];
        `FEPT_SEL_PRBS23: fb_bit = s[22] ^ s[17];
        `FEPT_SEL_PRBS31: fb_bit = s[30] ^ s[27];
        default: fb_bit = ~s[0];
      endcase
    end
  endfunction

  // ***************************************************************
  // bus decode
  // ***************************************************************
  wire req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire [5:0] idx = I_WB_ADR[7:2];
  wire wr = req & I_WB_WE;
  wire rd = req & ~I_WB_WE;
  wire rd_event = rd & (idx == `FEPT_IDX_EVENT);
  wire rd_tally = rd & (idx == `FEPT_IDX_RX_TALLY);
  wire rd_low = rd & (idx == `FEPT_IDX_PAT_LOW);
  wire wr_ctrl = wr & (idx == `FEPT_IDX_PAT_CTRL);
  wire soft_rst = wr & (idx == `FEPT_IDX_SOFT_RESET) & I_WB_SEL[1] &
    I_WB_DAT[`FEPT_SOFT_RESET_BIT];

  reg [15:0] ctrl_ff;
  reg [15:0] event_ff;
  reg [15:0] rx_tally_ff;
  reg [31:0] pat_cnt_ff;
  reg [15:0] pat_high_ff;
  reg [31:0] nxt_dat;

  always @* begin
    nxt_dat = 32'h00000000;
    case (idx)
      `FEPT_IDX_EVENT: nxt_dat[15:0] = event_ff;
      `FEPT_IDX_RX_TALLY: nxt_dat[15:0] = rx_tally_ff;
      `FEPT_IDX_PAT_CTRL: nxt_dat[15:0] = ctrl_ff;
      `FEPT_IDX_PAT_LOW: nxt_dat[15:0] = pat_cnt_ff[15:0];
      `FEPT_IDX_PAT_HIGH: nxt_dat[15:0] = pat_high_ff;
      default: nxt_dat = 32'h00000000;
    endcase
  end

  // one-cycle ack for every access, mapped or not
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else begin
      O_WB_ACK <= req;
      if (rd) begin
        O_WB_DAT <= nxt_dat;
      end
    end
  end

  // ***************************************************************
  // control register
  // ***************************************************************
  wire gen_en = ctrl_ff[`FEPT_CT_GEN_EN];
  wire chk_en = ctrl_ff[`FEPT_CT_CHK_EN];
  wire [1:0] sel = ctrl_ff[`FEPT_CT_SEL_LO+1:`FEPT_CT_SEL_LO];
  wire lock_wait = ctrl_ff[`FEPT_CT_LOCK_WAIT];
  wire clr_pat = ctrl_ff[`FEPT_CT_CLEAR];
  reg [15:0] nxt_ctrl;

  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[`FEPT_CT_CLEAR] = 1'b0;
    if (wr_ctrl & I_WB_SEL[0]) begin
      nxt_ctrl[7:0] = I_WB_DAT[7:0];
    end
    if (wr_ctrl & I_WB_SEL[1]) begin
      nxt_ctrl[15:8] = I_WB_DAT[15:8];
    end
    if (soft_rst) begin
      // software reset drops only the enables and the clear strobe
      nxt_ctrl[`FEPT_CT_GEN_EN] = 1'b0;
      nxt_ctrl[`FEPT_CT_CHK_EN] = 1'b0;
      nxt_ctrl[`FEPT_CT_CLEAR] = 1'b0;
    end
  end

  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_ff <= `FEPT_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ***************************************************************
  // event latches
  // ***************************************************************
  reg [1:0] speed_ff;
  reg duplex_ff;
  reg link_ff;
  reg energy_ff;
  reg [15:0] ev_set;

  always @* begin
    ev_set = 16'h0000;
    ev_set[`FEPT_EV_SPEED] = (I_SPEED != speed_ff);
    ev_set[`FEPT_EV_DUPLEX] = (I_DUPLEX != duplex_ff);
    ev_set[`FEPT_EV_PAGE] = I_PAGE_RX;
    ev_set[`FEPT_EV_ANEG] = I_ANEG_DONE;
    ev_set[`FEPT_EV_LINK] = (I_LINK_UP != link_ff);
    ev_set[`FEPT_EV_SYMBOL] = I_SYMBOL_ERR;
    ev_set[`FEPT_EV_FALSE_CAR] = I_FALSE_CARRIER;
    ev_set[`FEPT_EV_FIFO] = I_FIFO_ERR;
    ev_set[`FEPT_EV_ENERGY] = (I_NO_ENERGY != energy_ff);
  end

  // an event in the same cycle as the clearing read survives the read
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      speed_ff <= 2'h0;
      duplex_ff <= 1'b0;
      link_ff <= 1'b0;
      energy_ff <= `FEPT_ENERGY_RST;
      event_ff <= 16'h0000;
    end else begin
      speed_ff <= I_SPEED;
      duplex_ff <= I_DUPLEX;
      link_ff <= I_LINK_UP;
      energy_ff <= I_NO_ENERGY;
      if (rd_event | soft_rst) begin
        event_ff <= ev_set;
      end else begin
        event_ff <= event_ff | ev_set;
      end
    end
  end

  // ***************************************************************
  // receive error tally
  // ***************************************************************
  wire rx_err = I_SYMBOL_ERR | I_FALSE_CARRIER;

  // soft reset deliberately not in this process
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_tally_ff <= 16'h0000;
    end else if (rd_tally) begin
      rx_tally_ff <= {15'h0000, rx_err};
    end else if (rx_err && rx_tally_ff != `FEPT_TALLY_MAX) begin
      rx_tally_ff <= rx_tally_ff + 16'h0001;
    end
  end

  // ***************************************************************
  // pattern generator
  // ***************************************************************
  reg [30:0] gen_ff;

  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gen_ff <= `FEPT_LFSR_SEED;
      O_PAT_TX <= 1'b0;
    end else if (gen_en) begin
      gen_ff <= {gen_ff[29:0], fb_bit(gen_ff, sel)};
      O_PAT_TX <= fb_bit(gen_ff, sel) ^ ctrl_ff[`FEPT_CT_INV_GEN];
    end else begin
      O_PAT_TX <= 1'b0;
    end
  end

  // ***************************************************************
  // pattern checker
  // ***************************************************************
  // self-synchronising: the expected bit comes from the received history
  wire rx_bit = I_PAT_RX ^ ctrl_ff[`FEPT_CT_INV_CHK];
  reg [30:0] chk_ff;
  reg [5:0] run_ff;
  reg [1:0] sel_seen_ff;
  wire bit_err = (rx_bit != fb_bit(chk_ff, sel));
  wire count_ok = chk_en & (O_PAT_LOCK | ~lock_wait);
  wire pat_inc = count_ok & bit_err;

  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chk_ff <= 31'h00000000;
      run_ff <= 6'h00;
      sel_seen_ff <= `FEPT_SEL_PRBS7;
      O_PAT_LOCK <= 1'b0;
    end else begin
      sel_seen_ff <= sel;
      if (!chk_en || sel != sel_seen_ff) begin
        // lock is re-earned after a disable or a pattern change
        run_ff <= 6'h00;
        O_PAT_LOCK <= 1'b0;
      end else begin
        chk_ff <= {chk_ff[29:0], rx_bit};
        if (bit_err) begin
          run_ff <= 6'h00;
        end else if (run_ff != LOCK_RUN[5:0]) begin
          run_ff <= run_ff + 6'h01;
        end else begin
          O_PAT_LOCK <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // checker error tally
  // ***************************************************************
  always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pat_cnt_ff <= 32'h00000000;
      pat_high_ff <= 16'h0000;
    end else begin
      if (clr_pat) begin
        pat_cnt_ff <= {31'h00000000, pat_inc};
      end else if (pat_inc && pat_cnt_ff != 32'hFFFFFFFF) begin
        pat_cnt_ff <= pat_cnt_ff + 32'h00000001;
      end
      if (clr_pat) begin
        pat_high_ff <= 16'h0000;
      end else if (rd_low) begin
        pat_high_ff <= pat_cnt_ff[31:16];
      end
    end
  end

endmodule

// file: sim/fept_props.sv
/* bus and event-flag checker for fept_top; assumes one bind per instance */
`timescale 1ns/10ps
module fept_props(
  input wire I_SYS_CLK,
  input wire I_RST_B,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  input wire [1:0] I_SPEED,
  input wire I_DUPLEX,
  input wire I_PAGE_RX,
  input wire I_LINK_UP,
  input wire I_SYMBOL_ERR,
  input wire I_FALSE_CARRIER,
  input wire I_FIFO_ERR,
  input wire O_PAT_LOCK
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);
  // read data of the event register is valid while ack stands
  wire ev_rd = O_WB_ACK && !I_WB_WE && I_WB_ADR[7:2] == 6'h13;
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack stood longer than one cycle");
  a_ack_latency: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("request not answered on the next cycle");
  a_ack_cause: assert property (!$past(I_WB_CYC && I_WB_STB) |-> !O_WB_ACK)
    else $error("ack without a request");
  a_dat_hold: assert property (!O_WB_ACK |-> $stable(O_WB_DAT))
    else $error("read data moved outside ack");
  a_rsvd_zero: assert property (ev_rd |-> (O_WB_DAT & 32'hFFFF806F) == 0)
    else $error("reserved event bits not zero");
  a_pulse_latch: assert property (ev_rd |-> (O_WB_DAT[12] || !$past(I_PAGE_RX, 2)) &&
    (O_WB_DAT[9] || !$past(I_SYMBOL_ERR, 2)) && (O_WB_DAT[8] || !$past(I_FALSE_CARRIER, 2))
    && (O_WB_DAT[7] || !$past(I_FIFO_ERR, 2))) else $error("pulse event not latched");
  a_speed_latch: assert property (ev_rd && $past(I_SPEED, 2) != $past(I_SPEED, 3)
    |-> O_WB_DAT[14]) else $error("speed change not latched");
  a_level_latch: assert property (ev_rd |-> (O_WB_DAT[13] ||
    $past(I_DUPLEX, 2) == $past(I_DUPLEX, 3)) && (O_WB_DAT[10] ||
    $past(I_LINK_UP, 2) == $past(I_LINK_UP, 3))) else $error("level change not latched");
  cover property (ev_rd);
  cover property ($rose(O_PAT_LOCK));
  cover property (O_WB_ACK && I_WB_WE);
endmodule
bind fept_top fept_props chk_u(.I_SYS_CLK, .I_RST_B, .I_WB_CYC, .I_WB_STB, .I_WB_WE,
  .I_WB_ADR, .O_WB_DAT, .O_WB_ACK, .I_SPEED, .I_DUPLEX, .I_PAGE_RX, .I_LINK_UP,
  .I_SYMBOL_ERR, .I_FALSE_CARRIER, .I_FIFO_ERR, .O_PAT_LOCK);

// file: sim/fept_far.sv
/* far-side loopback of the pattern line; assumes the bench drives i_flip */
`timescale 1ns/10ps
module fept_far(
  input wire i_tx,
  input wire i_flip,
  output wire o_rx
);
  // a flip held for one cycle corrupts exactly one received bit
  assign o_rx = i_tx ^ i_flip;
endmodule

// file: sim/fept_top_test.sv
/* self-checking bench for fept_top; assumes fept_far loops the pattern back */
`timescale 1ns/10ps
module fept_top_test;
  reg clk = 0;
  reg rst_b = 0;
  reg cyc = 0;
  reg stb = 0;
  reg we = 0;
  reg flip = 0;
  reg [7:0] adr = 0;
  reg [31:0] wd = 0;
  // speed, duplex, page, aneg, link, symbol, false carrier, fifo, no energy
  reg [9:0] st = 10'h001;
  reg [30:0] h;
  reg [31:0] exp_q[$];
  reg [31:0] e;
  wire [31:0] rd;
  wire ack, prx, ptx, plk;
  integer miscompares = 0, samples_checked = 0, s, k, i, bad;
  fept_top #(.LOCK_RUN(6'h04)) dut_u(.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h3), .I_WB_DAT(wd),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .I_SPEED(st[9:8]), .I_DUPLEX(st[7]), .I_PAGE_RX(st[6]),
    .I_ANEG_DONE(st[5]), .I_LINK_UP(st[4]), .I_SYMBOL_ERR(st[3]), .I_FALSE_CARRIER(st[2]),
    .I_FIFO_ERR(st[1]), .I_NO_ENERGY(st[0]), .I_PAT_RX(prx), .O_PAT_TX(ptx),
    .O_PAT_LOCK(plk));
  fept_far far_u(.i_tx(ptx), .i_flip(flip), .o_rx(prx));
  initial forever #20 clk = ~clk;
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // for a read, d is the expected data; all ones marks a value not checked
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      if (!w) exp_q.push_back(d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task pulses(input integer n);
    repeat (n) begin
      st <= 10'h298;
      @(posedge clk);
      st <= 10'h290;
      @(posedge clk);
    end
  endtask
  function fb(input [30:0] q, input [1:0] c);
    fb = c == 0 ? q[6] ^ q[5] : c == 1 ? q[22] ^ q[17] : c == 2 ? q[30] ^ q[27] : ~q[0];
  endfunction
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) begin
      e = exp_q.pop_front();
      if (e != 32'hFFFFFFFF) cmp(rd, e);
    end
  end
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #3200000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    k = $urandom(22);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(0, 8'h5C, 0);
    wb(0, 8'h80, 0);
    wb(1, 8'h4C, 32'hFFFF);
    wb(0, 8'h4C, 0);
    st <= 10'h2FE;
    @(posedge clk);
    st <= 10'h290;
    @(posedge clk);
    wb(0, 8'h4C, 32'h7F90);
    wb(0, 8'h4C, 0);
    wb(0, 8'h54, 1);
    k = $urandom % 6 + 2;
    pulses(k);
    wb(0, 8'h54, k);
    // inverted checker on a silent line errs on every cycle but one
    wb(1, 8'h5C, 32'h82);
    st <= 10'h298;
    repeat (65540) @(posedge clk);
    st <= 10'h290;
    wb(0, 8'h64, 0);
    wb(0, 8'h54, 32'hFFFF);
    wb(0, 8'h60, 32'hFFFFFFFF);
    wb(0, 8'h64, 1);
    wb(0, 8'h54, 0);
    pulses(3);
    wb(1, 8'h00, 32'h8000);
    wb(0, 8'h54, 3);
    wb(0, 8'h5C, 32'h80);
    wb(1, 8'h5C, 32'h90);
    wb(0, 8'h5C, 32'h80);
    wb(0, 8'h60, 0);
    wb(0, 8'h64, 0);
    wb(1, 8'h5C, 32'hA2);
    repeat (50) @(posedge clk);
    wb(0, 8'h60, 0);
    for (s = 0; s < 4; s = s + 1) begin
      wb(1, 8'h5C, 32'h03 | (s << 2));
      repeat (40) @(posedge clk);
      wb(1, 8'h5C, 32'h13 | (s << 2));
      cmp(plk, 1'b1);
      k = $urandom % 3 + 1;
      bad = 0;
      for (i = 0; i < 160; i = i + 1) begin
        @(posedge clk);
        flip <= i % 40 == 5 && i < k * 40;
        if (i > 31 && ptx !== fb(h, s[1:0])) bad = bad + 1;
        h = {h[29:0], ptx};
      end
      cmp(bad, 0);
      // one wrong bit also spoils the checks where it later sits at a tap
      wb(0, 8'h60, k * (s == 3 ? 2 : 3));
    end
    // inverted generator: the line carries the complement of the 7-stage sequence
    wb(1, 8'h5C, 32'h41);
    bad = 0;
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge clk);
      if (i > 10 && ptx !== ~fb(h, 2'h0)) bad = bad + 1;
      h = {h[29:0], ~ptx};
    end
    cmp(bad, 0);
    tally_and_finish;
  end
endmodule
